// File: rtl/position_ring_and_compare.sv
// Position ring counters and four compare channels with Avalon-MM register access
`timescale 1ns/1ps
module position_ring_and_compare
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low except sync_action_sets, which clears
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  input wire logic drive_pulse, // One drive pulse output this cycle
  input wire logic drive_dir_neg, // Drive pulse direction is negative
  input wire logic encoder_up, // Encoder count up pulse
  input wire logic encoder_down, // Encoder count down pulse
  input wire logic [31:0] present_drive_speed, // Current drive speed
  input wire logic [31:0] present_timer_value, // Current timer value
  output logic [3:0] shared_io_pins_upper, // Compare outputs on pins 4 to 7
  output logic [3:0] shared_io_pins_upper_sel, // Pin selected as compare output
  output logic [3:0] sync_action_sets // Activation pulses per compare
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] data_low_reg;
  logic [31:0] data_high_reg;
  logic [31:0] read_data_reg;
  logic [31:0] commanded_ring_max_reg;
  logic [31:0] feedback_ring_max_reg;
  logic [31:0] commanded_position_reg;
  logic [31:0] feedback_position_reg;
  logic [15:0] cmp_mode_reg;
  logic [15:0] pin_func_reg;
  logic [31:0] compare_register [0:3];
  logic [3:0] cmp_result_reg;
  logic [3:0] cmp_prev_reg;
  logic [31:0] avs_readdata_reg;
  logic ack_reg;
  logic [31:0] commanded_position_next;
  logic [31:0] feedback_position_next;
  logic [31:0] read_data_next;
  logic [3:0] cmp_now;
  logic [3:0] edge_hit;

  wire logic [31:0] cmd_value = {data_high_reg[15:0], data_low_reg[15:0]};
  wire logic bus_req = (avs_read | avs_write) & ~ack_reg;
  // Writes commit only on the edge at which waitrequest is seen low
  wire logic wr_take = ce & avs_write & ack_reg;
  wire logic cmd_strobe = wr_take & (avs_address == ring_cmp_pkg::ADDR_COMMAND);
  wire logic [7:0] cmd_code = avs_writedata[7:0];
  wire logic cmd_is_cmp_wr = (cmd_code & ring_cmp_pkg::CMD_CMP_MASK) == ring_cmp_pkg::CMD_CMP_WRITE0;
  wire logic cmd_is_cmp_rd = (cmd_code & ring_cmp_pkg::CMD_CMP_MASK) == ring_cmp_pkg::CMD_CMP_READ0;
  wire logic [1:0] cmd_idx = cmd_code[1:0];

  ////////////////////////////////////////////////////////////////////////
  // Ring counters: up past max wraps to 0, down from 0 wraps to max
  always_comb
  begin
    commanded_position_next = commanded_position_reg;
    if (drive_pulse)
    begin
      if (drive_dir_neg)
        commanded_position_next = (commanded_position_reg == ring_cmp_pkg::POS_RESET) ?
          commanded_ring_max_reg : commanded_position_reg - 32'h00000001;
      else
        commanded_position_next = (commanded_position_reg == commanded_ring_max_reg) ?
          ring_cmp_pkg::POS_RESET : commanded_position_reg + 32'h00000001;
    end
    feedback_position_next = feedback_position_reg;
    if (encoder_up & ~encoder_down)
      feedback_position_next = (feedback_position_reg == feedback_ring_max_reg) ?
        ring_cmp_pkg::POS_RESET : feedback_position_reg + 32'h00000001;
    else if (encoder_down & ~encoder_up)
      feedback_position_next = (feedback_position_reg == ring_cmp_pkg::POS_RESET) ?
        feedback_ring_max_reg : feedback_position_reg - 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare channels, evaluated every cycle
  genvar k;
  generate
    for (k = 0; k < ring_cmp_pkg::NUM_CMP; k++)
    begin : g_cmp
      logic [1:0] src_sel;
      logic [1:0] cond_sel;
      logic signed [31:0] src_val;
      logic signed [31:0] ref_val;
      assign src_sel = cmp_mode_reg[k*ring_cmp_pkg::MODE_STRIDE +: ring_cmp_pkg::FIELD_W];
      assign cond_sel = cmp_mode_reg[k*ring_cmp_pkg::MODE_STRIDE + ring_cmp_pkg::COND_OFS +:
        ring_cmp_pkg::FIELD_W];
      assign src_val = (src_sel == ring_cmp_pkg::SRC_COMMANDED) ? commanded_position_reg :
        (src_sel == ring_cmp_pkg::SRC_FEEDBACK) ? feedback_position_reg :
        (src_sel == ring_cmp_pkg::SRC_SPEED) ? present_drive_speed : present_timer_value;
      assign ref_val = compare_register[k];
      assign cmp_now[k] = (cond_sel == ring_cmp_pkg::COND_GE) ? (src_val >= ref_val) :
        (cond_sel == ring_cmp_pkg::COND_GT) ? (src_val > ref_val) :
        (cond_sel == ring_cmp_pkg::COND_EQ) ? (src_val == ref_val) : (src_val < ref_val);
      assign edge_hit[k] = cmp_result_reg[k] & ~cmp_prev_reg[k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Command read-back value
  always_comb
  begin
    read_data_next = read_data_reg;
    if (cmd_strobe)
    begin
      if (cmd_is_cmp_rd)
        read_data_next = compare_register[cmd_idx];
      else if (cmd_code == ring_cmp_pkg::CMD_CMP_MODE_READ)
        read_data_next = {16'h0000, cmp_mode_reg};
    end
  end

  wire logic [31:0] rd_mux =
    (avs_address == ring_cmp_pkg::ADDR_DATA_LOW) ? data_low_reg :
    (avs_address == ring_cmp_pkg::ADDR_DATA_HIGH) ? data_high_reg :
    (avs_address == ring_cmp_pkg::ADDR_READ_DATA) ? read_data_reg :
    (avs_address == ring_cmp_pkg::ADDR_COMMANDED_POS) ? commanded_position_reg :
    (avs_address == ring_cmp_pkg::ADDR_FEEDBACK_POS) ? feedback_position_reg :
    (avs_address == ring_cmp_pkg::ADDR_CMP_STATUS) ? {28'h0000000, cmp_result_reg} :
    (avs_address == ring_cmp_pkg::ADDR_COMMANDED_MAX) ? commanded_ring_max_reg :
    (avs_address == ring_cmp_pkg::ADDR_FEEDBACK_MAX) ? feedback_ring_max_reg :
    (avs_address == ring_cmp_pkg::ADDR_CMP_MODE) ? {16'h0000, cmp_mode_reg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, acknowledged on the second cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_reg <= 1'b0;
      avs_readdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      ack_reg <= bus_req;
      avs_readdata_reg <= rd_mux;
    end
  end
  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata = avs_readdata_reg;

  // Host-visible data and configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      data_low_reg <= 32'h00000000;
      data_high_reg <= 32'h00000000;
      read_data_reg <= 32'h00000000;
      commanded_ring_max_reg <= ring_cmp_pkg::RING_MAX_RESET;
      feedback_ring_max_reg <= ring_cmp_pkg::RING_MAX_RESET;
      cmp_mode_reg <= 16'h0000;
      pin_func_reg <= 16'h0000;
    end
    else if (ce)
    begin
      read_data_reg <= read_data_next;
      if (wr_take & (avs_address == ring_cmp_pkg::ADDR_DATA_LOW))
        data_low_reg <= {16'h0000, avs_writedata[15:0]};
      if (wr_take & (avs_address == ring_cmp_pkg::ADDR_DATA_HIGH))
        data_high_reg <= {16'h0000, avs_writedata[15:0]};
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_COMMANDED_MAX))
        commanded_ring_max_reg <= cmd_value;
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_FEEDBACK_MAX))
        feedback_ring_max_reg <= cmd_value;
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_CMP_MODE_WRITE))
        cmp_mode_reg <= cmd_value[15:0];
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_PIN_FUNCTION))
        pin_func_reg <= cmd_value[15:0];
    end
  end

  // Compare registers hold no reset value
  always_ff @(posedge clk)
  begin
    if (ce & cmd_strobe & cmd_is_cmp_wr)
      compare_register[cmd_idx] <= cmd_value;
  end

  // Position counters: host load overrides counting
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      commanded_position_reg <= ring_cmp_pkg::POS_RESET;
      feedback_position_reg <= ring_cmp_pkg::POS_RESET;
    end
    else if (ce)
    begin
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_LOAD_COMMANDED))
        commanded_position_reg <= cmd_value;
      else
        commanded_position_reg <= commanded_position_next;
      if (cmd_strobe & (cmd_code == ring_cmp_pkg::CMD_LOAD_FEEDBACK))
        feedback_position_reg <= cmd_value;
      else
        feedback_position_reg <= feedback_position_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare results, pins and activation events
  genvar p;
  generate
    for (p = 0; p < ring_cmp_pkg::NUM_CMP; p++)
    begin : g_pin
      wire logic pin_sel = pin_func_reg[ring_cmp_pkg::PIN_SEL_BASE + ring_cmp_pkg::FIELD_W*p +:
        ring_cmp_pkg::FIELD_W] == ring_cmp_pkg::PIN_SEL_COMPARE;
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          shared_io_pins_upper[p] <= 1'b0;
          shared_io_pins_upper_sel[p] <= 1'b0;
        end
        else if (ce)
        begin
          shared_io_pins_upper[p] <= pin_sel & cmp_now[p];
          shared_io_pins_upper_sel[p] <= pin_sel;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmp_result_reg <= 4'h0;
      cmp_prev_reg <= 4'h0;
      sync_action_sets <= 4'h0;
    end
    else if (ce)
    begin
      cmp_result_reg <= cmp_now;
      cmp_prev_reg <= cmp_result_reg;
      sync_action_sets <= edge_hit;
    end
    else
      sync_action_sets <= 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_wrap_up_zero: assert property (@(posedge clk) disable iff (srst)
    (ce && !(cmd_strobe && cmd_code == ring_cmp_pkg::CMD_LOAD_COMMANDED) && drive_pulse && !drive_dir_neg
     && commanded_position_reg == commanded_ring_max_reg) |=> commanded_position_reg == 32'h00000000)
    else $error("commanded counter did not wrap to zero");
  chk_wrap_down_max: assert property (@(posedge clk) disable iff (srst)
    (ce && !(cmd_strobe && cmd_code == ring_cmp_pkg::CMD_LOAD_COMMANDED) && drive_pulse && drive_dir_neg
     && commanded_position_reg == 32'h00000000) |=> commanded_position_reg == $past(commanded_ring_max_reg))
    else $error("commanded counter did not wrap to maximum");
  chk_fb_wrap_up: assert property (@(posedge clk) disable iff (srst)
    (ce && !(cmd_strobe && cmd_code == ring_cmp_pkg::CMD_LOAD_FEEDBACK) && encoder_up && !encoder_down
     && feedback_position_reg == feedback_ring_max_reg) |=> feedback_position_reg == 32'h00000000)
    else $error("feedback counter did not wrap");
  chk_max_reset: assert property (@(posedge clk) $fell(srst) |->
    commanded_ring_max_reg == ring_cmp_pkg::RING_MAX_RESET && feedback_ring_max_reg == ring_cmp_pkg::RING_MAX_RESET)
    else $error("ring maximum reset value wrong");
  chk_max_latch: assert property (@(posedge clk) disable iff (srst)
    (cmd_strobe && cmd_code == ring_cmp_pkg::CMD_FEEDBACK_MAX) |=> feedback_ring_max_reg == $past(cmd_value))
    else $error("feedback ring maximum not latched");
  chk_mode_update: assert property (@(posedge clk) disable iff (srst)
    (cmd_strobe && cmd_code == ring_cmp_pkg::CMD_CMP_MODE_WRITE) |=> cmp_mode_reg == $past(cmd_value[15:0]))
    else $error("compare mode not updated");
  chk_mode_read: assert property (@(posedge clk) disable iff (srst)
    (cmd_strobe && cmd_code == ring_cmp_pkg::CMD_CMP_MODE_READ) |=> read_data_reg[15:0] == $past(cmp_mode_reg))
    else $error("compare mode read back wrong");
  sequence s_rise(int i);
    !cmp_result_reg[i] ##1 cmp_result_reg[i];
  endsequence
  chk_edge_event: assert property (@(posedge clk) disable iff (srst || !ce)
    s_rise(0) ##1 ce |-> sync_action_sets[0])
    else $error("activation pulse missing");
  chk_no_steady: assert property (@(posedge clk) disable iff (srst)
    (cmp_prev_reg[1] && ce) |=> !sync_action_sets[1])
    else $error("activation without rising edge");
  chk_pin_gate: assert property (@(posedge clk) disable iff (srst)
    !shared_io_pins_upper_sel[2] |-> !shared_io_pins_upper[2])
    else $error("pin driven while not selected");
endmodule

// File: include/ring_cmp_pkg.sv
// Constants shared by the position ring and compare block
package ring_cmp_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CMP = 4;
  // Avalon word addresses (byte address / 4)
  localparam logic [3:0] ADDR_DATA_LOW = 4'h0;
  localparam logic [3:0] ADDR_DATA_HIGH = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_READ_DATA = 4'h3;
  localparam logic [3:0] ADDR_COMMANDED_POS = 4'h4;
  localparam logic [3:0] ADDR_FEEDBACK_POS = 4'h5;
  localparam logic [3:0] ADDR_CMP_STATUS = 4'h6;
  localparam logic [3:0] ADDR_COMMANDED_MAX = 4'h7;
  localparam logic [3:0] ADDR_FEEDBACK_MAX = 4'h8;
  localparam logic [3:0] ADDR_CMP_MODE = 4'h9;
  // Command codes
  localparam logic [7:0] CMD_COMMANDED_MAX = 8'h0E;
  localparam logic [7:0] CMD_FEEDBACK_MAX = 8'h0F;
  localparam logic [7:0] CMD_CMP_WRITE0 = 8'h10;
  localparam logic [7:0] CMD_CMP_READ0 = 8'h34;
  localparam logic [7:0] CMD_CMP_MODE_WRITE = 8'h20;
  localparam logic [7:0] CMD_PIN_FUNCTION = 8'h21;
  localparam logic [7:0] CMD_CMP_MODE_READ = 8'h40;
  localparam logic [7:0] CMD_LOAD_COMMANDED = 8'h09;
  localparam logic [7:0] CMD_LOAD_FEEDBACK = 8'h0A;
  localparam logic [7:0] CMD_CMP_MASK = 8'hFC;
  // Reset values and field layout
  localparam logic [31:0] RING_MAX_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] POS_RESET = 32'h00000000;
  localparam int unsigned FIELD_W = 2;
  localparam int unsigned MODE_STRIDE = 4;
  localparam int unsigned COND_OFS = 2;
  localparam int unsigned PIN_SEL_BASE = 8;
  localparam logic [1:0] PIN_SEL_COMPARE = 2'h3;
  localparam logic [1:0] SRC_COMMANDED = 2'h0;
  localparam logic [1:0] SRC_FEEDBACK = 2'h1;
  localparam logic [1:0] SRC_SPEED = 2'h2;
  localparam logic [1:0] SRC_TIMER = 2'h3;
  localparam logic [1:0] COND_GE = 2'h0;
  localparam logic [1:0] COND_GT = 2'h1;
  localparam logic [1:0] COND_EQ = 2'h2;
  localparam logic [1:0] COND_LT = 2'h3;
endpackage

// File: test/host_cpu_model.sv
// Host-side Avalon-MM master that issues register cycles and commands
`timescale 1ns/1ps
module host_cpu_model
(
  input wire logic clk, // System clock
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Wait request
  output logic [3:0] avs_address, // Word address
  output logic avs_read, // Read request
  output logic avs_write, // Write request
  output logic [31:0] avs_writedata // Write data
);
  initial
  begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request held until waitrequest is seen low; released data is inverted
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // Low half, high half, then the code
  task automatic cmd(input logic [7:0] code, input logic [31:0] v);
    bus_write(4'h0, {16'h0000, v[15:0]});
    bus_write(4'h1, {16'h0000, v[31:16]});
    bus_write(4'h2, {24'h000000, code});
  endtask
endmodule

// File: test/position_ring_and_compare_tb_top.sv
// Self-checking bench for the position ring and compare block
`timescale 1ns/1ps
module position_ring_and_compare_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic drive_pulse = 1'b0, drive_dir_neg = 1'b0, encoder_up = 1'b0, encoder_down = 1'b0;
  logic [31:0] speed = 32'h00000000, timer = 32'h00000000;
  logic [3:0] avs_address, pins, pin_sel, sync;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_fail = 0;
  int compares = 0;
  int seed = 14;
  int n_sync = 0;
  int r, v, m, e;

  always #5 clk = ~clk;
  always @(posedge clk) if (sync === 4'hF) n_sync <= n_sync + 1;

  position_ring_and_compare DUT (.clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_pulse(drive_pulse), .drive_dir_neg(drive_dir_neg),
    .encoder_up(encoder_up), .encoder_down(encoder_down), .present_drive_speed(speed),
    .present_timer_value(timer), .shared_io_pins_upper(pins), .shared_io_pins_upper_sel(pin_sel),
    .sync_action_sets(sync));
  host_cpu_model host (.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check4(input string name, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string name);
    host.bus_read(a, rd);
    check32(name, exp, rd);
  endtask
  task automatic step(input logic dp, input logic neg, input logic up, input logic dn);
    drive_pulse <= dp;
    drive_dir_neg <= neg;
    encoder_up <= up;
    encoder_down <= dn;
    @(posedge clk);
    drive_pulse <= 1'b0;
    encoder_up <= 1'b0;
    encoder_down <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic hit(input int s, input int r, input int c);
    case (c)
      0: return s >= r;
      1: return s > r;
      2: return s == r;
      default: return s < r;
    endcase
  endfunction
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(4'h7, 32'hFFFFFFFF, "commanded_max");
    rdchk(4'h8, 32'hFFFFFFFF, "feedback_max");
    rdchk(4'hF, 32'h00000000, "unmapped");
    host.bus_write(4'h4, $random(seed));
    rdchk(4'h4, 32'h00000000, "read_only_pos");
    check4("pin_sel", 4'h0, pin_sel);
    check4("pins", 4'h0, pins);
    $display("test reset done");
    step(1'b1, 1'b1, 1'b0, 1'b1);
    rdchk(4'h4, 32'hFFFFFFFF, "commanded_down");
    rdchk(4'h5, 32'hFFFFFFFF, "feedback_down");
    step(1'b1, 1'b0, 1'b1, 1'b0);
    rdchk(4'h4, 32'h00000000, "commanded_up");
    rdchk(4'h5, 32'h00000000, "feedback_up");
    ce <= 1'b0;
    step(1'b1, 1'b0, 1'b1, 1'b0);
    ce <= 1'b1;
    step(1'b0, 1'b0, 1'b1, 1'b1);
    rdchk(4'h4, 32'h00000000, "frozen_pos");
    rdchk(4'h5, 32'h00000000, "both_encoder");
    $display("test default wrap done");
    for (int k = 0; k < 4; k++)
    begin
      v = $random(seed);
      host.cmd(8'h10 + 8'(k), v);
      host.bus_write(4'h2, {24'h000000, 8'h34 + 8'(k)});
      rdchk(4'h3, v, "compare_reg");
    end
    m = $random(seed) & 32'h0000FFFF;
    host.cmd(8'h20, m);
    host.bus_write(4'h2, 32'h00000040);
    rdchk(4'h3, m, "mode_read");
    host.cmd(8'h21, 32'h0000FF00);
    repeat (2) @(posedge clk);
    check4("pin_sel", 4'hF, pin_sel);
    $display("test register access done");
    // Channel k uses condition k, all on the same source
    for (int s = 0; s < 4; s++)
    begin
      r = $random(seed) >>> 2;
      m = 0;
      for (int k = 0; k < 4; k++)
        m |= ((k << 2) | s) << (4 * k);
      for (int k = 0; k < 4; k++)
        host.cmd(8'h10 + 8'(k), r);
      host.cmd(8'h20, m);
      for (int d = -1; d < 2; d++)
      begin
        v = r + d;
        case (s)
          0: host.cmd(8'h09, v);
          1: host.cmd(8'h0A, v);
          2: speed <= v;
          default: timer <= v;
        endcase
        repeat (3) @(posedge clk);
        e = 0;
        for (int k = 0; k < 4; k++)
          e |= int'(hit(v, r, k)) << k;
        host.bus_read(4'h6, rd);
        check4("status", 4'(e), rd[3:0]);
        check4("pins", 4'(e), pins);
      end
    end
    $display("test compare done");
    // All four channels watch speed >= 100, so all four pulse together
    for (int k = 0; k < 4; k++)
      host.cmd(8'h10 + 8'(k), 32'h00000064);
    host.cmd(8'h20, 32'h00002222);
    for (int t = 1; t < 3; t++)
    begin
      speed <= 32'h00000000;
      repeat (4) @(posedge clk);
      e = n_sync;
      speed <= 32'h000000C8;
      repeat (10) @(posedge clk);
      check32("sync_count", 32'(e + 1), 32'(n_sync));
    end
    $display("test activation done");
    for (int c = 0; c < 2; c++)
    begin
      v = ($random(seed) & 32'h7FFFFFFF) | 32'h00000001;
      host.cmd(8'h0E + 8'(c), v);
      rdchk(4'h7 + 4'(c), v, "ring_max");
      host.cmd(8'h09 + 8'(c), v);
      step(c == 0, 1'b0, c == 1, 1'b0);
      rdchk(4'h4 + 4'(c), 32'h00000000, "ring_up");
      step(c == 0, 1'b1, 1'b0, c == 1);
      rdchk(4'h4 + 4'(c), v, "ring_down");
    end
    $display("test ring done");
    stop_test();
  end
endmodule
